// >>> rtl/serc_event_combiner.sv
// Purpose: combine host and network event requests into the two interrupt paths
// Assumes: all inputs come from logic on ref_clk, no crossing needed
// Notes: serial-host frame start returns interrupt state before addressed data
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - host request ANDed with host mask, all bits ORed to host interrupt.
// - host config register selects host interrupt pin driver behaviour.
// - sync map bits feed sync outputs into host request register.
// - mapped sync outputs share one interrupt line; both latch inputs still work.
// - direct sync use leaves latch on one input, or none if both used.
// - channel control register enables host and network requests per channel.
// - network request ANDed bitwise with network mask.
// - masked network bits ORed into passing datagram interrupt field.
// - no slave identification added to datagram interrupt field.
// - serial access start returns sampled pending-interrupt state first.
// - abandoned host read counts as host interface error.
// - reading a channel buffer with new data clears its request.
// - reading a latch time register clears its latch request.
module serc_event_combiner (
  input wire logic ref_clk, // system clock, 250 MHz
  input wire logic rst, // synchronous reset, active high
  input wire serc_pkg::serc_reg_req_t host_req, // host register access
  input wire serc_pkg::serc_reg_req_t net_req, // network register access
  output logic [15:0] host_rdata, // host read data
  output logic [15:0] net_rdata, // network read data
  input wire serc_pkg::serc_events_t events, // event sources
  input wire logic serial_access_start, // serial host frame begins
  input wire logic host_read_abort, // host abandoned a read
  output logic host_if_error, // abandoned-read error pulse
  output logic [15:0] serial_irq_status, // sampled pending state
  input wire serc_pkg::serc_dgram_t dgram_in, // incoming irq field
  output serc_pkg::serc_dgram_t dgram_out, // outgoing irq field
  output logic host_irq_o, // host interrupt pin output level
  output logic host_irq_oe, // host interrupt pin enable
  output logic [1:0] latch_enable // latch inputs usable
);
  logic [7:0] host_if_config;
  logic [7:0] sync_latch_config;
  logic [15:0] net_mask;
  logic [31:0] host_mask;
  logic [7:0] chan_ctrl [serc_pkg::NUM_CHAN];
  logic [31:0] host_event_request;
  logic [15:0] net_event_request;
  logic [31:0] next_host_req;
  logic [15:0] next_net_req;
  logic [31:0] host_set;
  logic [15:0] net_set;
  logic [31:0] host_clr;
  logic [15:0] net_clr;
  logic [1:0] sync_prev;
  logic host_pending;
  logic net_wr_hit;

  // per-channel host and network enable bits
  logic [serc_pkg::NUM_CHAN-1:0] ch_host_en;
  logic [serc_pkg::NUM_CHAN-1:0] ch_net_en;
  genvar gi;
  generate
    for (gi = 0; gi < serc_pkg::NUM_CHAN; gi++) begin : g_chan
      assign ch_host_en[gi] = chan_ctrl[gi][serc_pkg::CHAN_HOST_EN_BIT];
      assign ch_net_en[gi] = chan_ctrl[gi][serc_pkg::CHAN_NET_EN_BIT];
    end
  endgenerate

  // set and clear terms of both request registers
  always_comb begin
    host_set = {events.other_host_ev, 16'h0000};
    host_set[serc_pkg::HOST_REQ_CHAN_BASE +: serc_pkg::NUM_CHAN] =
      events.chan_new_data & ch_host_en;
    host_set[serc_pkg::HOST_REQ_LATCH_BIT] = |events.latch_event;
    host_set[serc_pkg::HOST_REQ_SYNC0_BIT] = sync_latch_config[serc_pkg::SYNC0_MAP_BIT]
      & events.sync_out[0] & ~sync_prev[0];
    host_set[serc_pkg::HOST_REQ_SYNC1_BIT] = sync_latch_config[serc_pkg::SYNC1_MAP_BIT]
      & events.sync_out[1] & ~sync_prev[1];
    host_clr = 32'h00000000;
    host_clr[serc_pkg::HOST_REQ_CHAN_BASE +: serc_pkg::NUM_CHAN] = events.chan_buf_read;
    host_clr[serc_pkg::HOST_REQ_LATCH_BIT] = |events.latch_time_read;
    host_clr[serc_pkg::HOST_REQ_SYNC0_BIT] = ~events.sync_out[0];
    host_clr[serc_pkg::HOST_REQ_SYNC1_BIT] = ~events.sync_out[1];
    net_set = events.other_net_ev;
    net_set[serc_pkg::NET_REQ_CHAN_BASE +: serc_pkg::NUM_CHAN] =
      events.chan_new_data & ch_net_en;
    net_set[serc_pkg::NET_REQ_LATCH_BIT] = |events.latch_event;
    net_clr = 16'h0000;
    net_clr[serc_pkg::NET_REQ_CHAN_BASE +: serc_pkg::NUM_CHAN] = events.chan_buf_read;
    net_clr[serc_pkg::NET_REQ_LATCH_BIT] = |events.latch_time_read;
    // set wins over clear; bits hold otherwise
    next_host_req = (host_event_request & ~host_clr) | host_set;
    next_net_req = (net_event_request & ~net_clr) | net_set;
  end

  // request registers, changed only by events and clearing actions
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_event_request <= 32'h00000000;
      net_event_request <= 16'h0000;
      sync_prev <= 2'h0;
    end else begin
      host_event_request <= next_host_req;
      net_event_request <= next_net_req;
      sync_prev <= events.sync_out;
    end
  end

  // host-owned configuration and mask writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_if_config <= serc_pkg::HOST_IF_CONFIG_RST;
      sync_latch_config <= serc_pkg::SYNC_LATCH_CONFIG_RST;
      host_mask <= serc_pkg::HOST_MASK_RST;
    end else if (host_req.wr) begin
      unique case (host_req.addr)
        serc_pkg::ADDR_HOST_IF_CONFIG: begin
          host_if_config <= host_req.wdata[7:0];
          sync_latch_config <= host_req.wdata[15:8];
        end
        serc_pkg::ADDR_HOST_MASK_LO: host_mask[15:0] <= host_req.wdata;
        serc_pkg::ADDR_HOST_MASK_HI: host_mask[31:16] <= host_req.wdata;
        default: ;
      endcase
    end
  end

  // network-owned mask and channel control writes
  assign net_wr_hit = net_req.wr && (net_req.addr >= serc_pkg::ADDR_CHAN_CTRL_BASE);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      net_mask <= serc_pkg::NET_MASK_RST;
      for (int i = 0; i < serc_pkg::NUM_CHAN; i++) begin
        chan_ctrl[i] <= serc_pkg::CHAN_CTRL_RST;
      end
    end else if (net_req.wr) begin
      if (net_req.addr == serc_pkg::ADDR_NET_MASK) begin
        net_mask <= net_req.wdata;
      end
      for (int i = 0; i < serc_pkg::NUM_CHAN; i++) begin
        if (net_wr_hit && net_req.addr == 16'(serc_pkg::ADDR_CHAN_CTRL_BASE
            + 16'(i) * serc_pkg::CHAN_STRIDE)) begin
          chan_ctrl[i] <= net_req.wdata[7:0];
        end
      end
    end
  end

  // register read mux shared by both sides
  function automatic logic [15:0] read_word(input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    unique case (a)
      serc_pkg::ADDR_HOST_IF_CONFIG: r = {sync_latch_config, host_if_config};
      serc_pkg::ADDR_NET_MASK: r = net_mask;
      serc_pkg::ADDR_HOST_MASK_LO: r = host_mask[15:0];
      serc_pkg::ADDR_HOST_MASK_HI: r = host_mask[31:16];
      serc_pkg::ADDR_NET_REQ: r = net_event_request;
      serc_pkg::ADDR_HOST_REQ_LO: r = host_event_request[15:0];
      serc_pkg::ADDR_HOST_REQ_HI: r = host_event_request[31:16];
      default: begin
        for (int i = 0; i < serc_pkg::NUM_CHAN; i++) begin
          if (a == 16'(serc_pkg::ADDR_CHAN_CTRL_BASE + 16'(i) * serc_pkg::CHAN_STRIDE)) begin
            r = {8'h00, chan_ctrl[i]};
          end
        end
      end
    endcase
    return r;
  endfunction

  // registered read data, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_rdata <= 16'h0000;
      net_rdata <= 16'h0000;
    end else begin
      if (host_req.rd) host_rdata <= read_word(host_req.addr);
      if (net_req.rd) net_rdata <= read_word(net_req.addr);
    end
  end

  // pending host interrupt from the next request value and current mask
  assign host_pending = |(next_host_req & host_mask);

  // host interrupt pin: level plus driver mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // idle level of the reset mode: active low, push-pull, not asserted
      host_irq_o <= 1'b1;
      host_irq_oe <= 1'b1;
    end else begin
      // polarity bit: 0 active low, 1 active high
      host_irq_o <= host_pending ~^ host_if_config[serc_pkg::IRQ_POL_BIT];
      // drive bit: 0 push-pull, 1 open drain (drive only while asserted, at either polarity)
      host_irq_oe <= ~host_if_config[serc_pkg::IRQ_DRIVE_BIT] | host_pending;
    end
  end

  // latch input availability from sync use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // map bits reset clear, so both sync outputs count as direct use
      latch_enable <= 2'b00;
    end else begin
      // each mapped sync output leaves its own latch free; direct use of it takes that latch away
      latch_enable[0] <= sync_latch_config[serc_pkg::SYNC0_MAP_BIT];
      latch_enable[1] <= sync_latch_config[serc_pkg::SYNC1_MAP_BIT];
    end
  end

  // serial access status and abandoned-read error
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serial_irq_status <= 16'h0000;
      host_if_error <= 1'b0;
    end else begin
      if (serial_access_start) serial_irq_status <= host_event_request[15:0];
      host_if_error <= host_read_abort;
    end
  end

  // datagram interrupt field: plain OR, nothing identifies this slave
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dgram_out <= '0;
    end else begin
      dgram_out.valid <= dgram_in.valid;
      dgram_out.irq_field <= dgram_in.irq_field | (next_net_req & net_mask);
    end
  end
endmodule

`default_nettype wire

// >>> rtl/serc_pkg.sv
// Purpose: constants and carriers for the slave event request combiner
// Assumes: byte-addressed register port of the slave controller, 16-bit words
// Notes: offsets are the register addresses of the controller
package serc_pkg;
  localparam logic [15:0] ADDR_HOST_IF_CONFIG = 16'h0150;
  localparam logic [15:0] ADDR_SYNC_LATCH_CONFIG = 16'h0151;
  localparam logic [15:0] ADDR_NET_MASK = 16'h0200;
  localparam logic [15:0] ADDR_HOST_MASK_LO = 16'h0204;
  localparam logic [15:0] ADDR_HOST_MASK_HI = 16'h0206;
  localparam logic [15:0] ADDR_NET_REQ = 16'h0210;
  localparam logic [15:0] ADDR_HOST_REQ_LO = 16'h0220;
  localparam logic [15:0] ADDR_HOST_REQ_HI = 16'h0222;
  localparam logic [15:0] ADDR_CHAN_CTRL_BASE = 16'h0804;
  localparam logic [15:0] CHAN_STRIDE = 16'h0008;
  localparam int NUM_CHAN = 8;
  // field positions
  localparam int SYNC0_MAP_BIT = 3;
  localparam int SYNC1_MAP_BIT = 7;
  localparam int CHAN_HOST_EN_BIT = 5;
  localparam int CHAN_NET_EN_BIT = 4;
  localparam int HOST_REQ_SYNC0_BIT = 2;
  localparam int HOST_REQ_SYNC1_BIT = 3;
  localparam int HOST_REQ_LATCH_BIT = 1;
  localparam int HOST_REQ_CHAN_BASE = 8;
  localparam int NET_REQ_LATCH_BIT = 1;
  localparam int NET_REQ_CHAN_BASE = 4;
  localparam int IRQ_DRIVE_BIT = 0;
  localparam int IRQ_POL_BIT = 1;
  // reset values
  localparam logic [7:0] HOST_IF_CONFIG_RST = 8'h00;
  localparam logic [7:0] SYNC_LATCH_CONFIG_RST = 8'h00;
  localparam logic [15:0] NET_MASK_RST = 16'h0000;
  localparam logic [31:0] HOST_MASK_RST = 32'h00000000;
  localparam logic [7:0] CHAN_CTRL_RST = 8'h00;

  // one register port access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } serc_reg_req_t;

  // event sources from the rest of the controller
  typedef struct packed {
    logic [NUM_CHAN-1:0] chan_new_data;
    logic [NUM_CHAN-1:0] chan_buf_read;
    logic [1:0] latch_event;
    logic [1:0] latch_time_read;
    logic [1:0] sync_out;
    logic [15:0] other_host_ev;
    logic [15:0] other_net_ev;
  } serc_events_t;

  // datagram interrupt field path
  typedef struct packed {
    logic valid;
    logic [15:0] irq_field;
  } serc_dgram_t;
endpackage

// >>> tb/serc_checker.sv
// Purpose: port-level checks of the event combiner
// Assumes: single clock, synchronous active-high reset
// Notes: attached by bind below the module
`timescale 1ns/10ps
`default_nettype none
module serc_checker (
  input wire logic ref_clk, // system clock
  input wire logic rst, // sync reset
  input wire serc_pkg::serc_reg_req_t host_req, // host access
  input wire serc_pkg::serc_reg_req_t net_req, // network access
  input wire logic [15:0] host_rdata, // host read data
  input wire logic [15:0] net_rdata, // network read data
  input wire logic host_read_abort, // abandoned read
  input wire logic host_if_error, // error pulse
  input wire logic serial_access_start, // serial frame start
  input wire logic [15:0] serial_irq_status, // sampled state
  input wire serc_pkg::serc_dgram_t dgram_in, // incoming field
  input wire serc_pkg::serc_dgram_t dgram_out // outgoing field
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // read of a place outside the map
  sequence bad_rd_s;
    host_req.rd && host_req.addr == 16'h0100;
  endsequence
  sequence err_s;
    ##1 host_if_error;
  endsequence
  unmapped_zero_a: assert property (bad_rd_s |=> host_rdata == 16'h0000)
    else $error("unmapped host read not zero");
  host_hold_a: assert property (!$past(host_req.rd) |-> $stable(host_rdata))
    else $error("host read data moved without read");
  net_hold_a: assert property (!$past(net_req.rd) |-> $stable(net_rdata))
    else $error("network read data moved without read");
  serial_hold_a: assert property (!$past(serial_access_start) |-> $stable(serial_irq_status))
    else $error("serial status moved without frame start");
  abort_err_a: assert property (host_read_abort |-> err_s)
    else $error("abandoned read gave no error");
  err_cause_a: assert property (host_if_error |-> $past(host_read_abort))
    else $error("error without abandoned read");
  dgram_valid_a: assert property (dgram_out.valid == $past(dgram_in.valid))
    else $error("datagram valid not passed one cycle later");
  dgram_or_a: assert property (dgram_out.valid |->
      (dgram_out.irq_field & $past(dgram_in.irq_field)) == $past(dgram_in.irq_field))
    else $error("incoming field bits lost");
endmodule
bind serc_event_combiner serc_checker chk_i (.ref_clk(ref_clk), .rst(rst), .host_req(host_req),
  .net_req(net_req), .host_rdata(host_rdata), .net_rdata(net_rdata),
  .host_read_abort(host_read_abort), .host_if_error(host_if_error),
  .serial_access_start(serial_access_start), .serial_irq_status(serial_irq_status),
  .dgram_in(dgram_in), .dgram_out(dgram_out));
`default_nettype wire

// >>> tb/serc_partner.sv
// Purpose: host and network master register access model
// Assumes: one access at a time, strobe up for one edge
// Notes: released lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module serc_partner (
  input wire logic ref_clk, // system clock
  output var serc_pkg::serc_reg_req_t host_req, // host access
  output var serc_pkg::serc_reg_req_t net_req, // network access
  input wire logic [15:0] host_rdata, // host read data
  input wire logic [15:0] net_rdata // network read data
);
  initial begin
    host_req = '0;
    net_req = '0;
  end
  // reads and writes never share one access
  task automatic acc(input logic net, input logic rd, input logic [15:0] a,
      input logic [15:0] d, output logic [15:0] q);
    serc_pkg::serc_reg_req_t r;
    r = {rd, ~rd, a, d};
    net_req = net ? r : net_req;
    host_req = net ? host_req : r;
    @(posedge ref_clk);
    #1;
    q = net ? net_rdata : host_rdata;
    r = {2'b00, ~a, ~d};
    net_req = net ? r : net_req;
    host_req = net ? host_req : r;
    @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> tb/serc_event_combiner_bench.sv
// Purpose: self-checking bench of the event combiner
// Assumes: inputs change 1 ns after the rising edge
// Notes: pin checks after config and mask writes wait three cycles
`timescale 1ns/10ps
`default_nettype none
module serc_event_combiner_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  serc_pkg::serc_reg_req_t host_req, net_req;
  serc_pkg::serc_events_t ev = '0;
  serc_pkg::serc_dgram_t dg_in = '0;
  serc_pkg::serc_dgram_t dg_out;
  logic [15:0] host_rdata, net_rdata, sirq, q;
  logic start = 1'b0;
  logic abort = 1'b0;
  logic err, irq_o, irq_oe;
  logic [1:0] latch_en;
  int n_errors = 0;
  int checks_done = 0;
  // {pin level expected, host mask}
  logic [32:0] rows [5] = '{33'h1_0000_0000, 33'h0_0001_0000, 33'h1_0002_0000,
    33'h1_FFFE_FFFF, 33'h0_FFFF_FFFF};
  serc_event_combiner dut (.ref_clk(ref_clk), .rst(rst), .host_req(host_req),
    .net_req(net_req), .host_rdata(host_rdata), .net_rdata(net_rdata), .events(ev),
    .serial_access_start(start), .host_read_abort(abort), .host_if_error(err),
    .serial_irq_status(sirq), .dgram_in(dg_in), .dgram_out(dg_out), .host_irq_o(irq_o),
    .host_irq_oe(irq_oe), .latch_enable(latch_en));
  serc_partner p (.ref_clk(ref_clk), .host_req(host_req), .net_req(net_req),
    .host_rdata(host_rdata), .net_rdata(net_rdata));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one-cycle event pulse
  task automatic pev(input serc_pkg::serc_events_t e);
    ev = e;
    tick(1);
    ev = '0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // cuts a hang short
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    tick(20);
    rst = 1'b0;
    chk({14'h0, latch_en}, 16'h0000, "latch use");
    chk({14'h0, irq_oe, irq_o}, 16'h0003, "idle pin");
    p.acc(0, 1, 16'h0204, 16'h0000, q);
    chk(q, 16'h0000, "host mask");
    p.acc(1, 1, 16'h0200, 16'h0000, q);
    chk(q, 16'h0000, "net mask");
    p.acc(0, 1, 16'h0100, 16'h0000, q);
    chk(q, 16'h0000, "unmapped");
    $display("reset test done");
    pev('{other_host_ev: 16'h0001, default: '0});
    p.acc(0, 0, 16'h0222, 16'hFFFE, q);
    p.acc(0, 1, 16'h0222, 16'h0000, q);
    chk(q, 16'h0001, "host request");
    foreach (rows[i]) begin
      p.acc(0, 0, 16'h0204, rows[i][15:0], q);
      p.acc(0, 0, 16'h0206, rows[i][31:16], q);
      tick(3);
      chk({14'h0, irq_oe, irq_o}, {14'h0, 1'b1, rows[i][32]}, "irq pin");
    end
    $display("mask table done");
    p.acc(0, 0, 16'h0150, 16'h0002, q);
    tick(3);
    chk({14'h0, irq_oe, irq_o}, 16'h0003, "high pin");
    p.acc(0, 0, 16'h0150, 16'h0003, q);
    p.acc(0, 0, 16'h0206, 16'h0000, q);
    tick(3);
    chk({15'h0, irq_oe}, 16'h0000, "open drain");
    p.acc(0, 0, 16'h0150, 16'h8800, q);
    tick(2);
    chk({14'h0, latch_en}, 16'h0003, "latch use");
    ev.sync_out = 2'b01;
    tick(3);
    p.acc(0, 1, 16'h0220, 16'h0000, q);
    chk(q, 16'h0004, "sync map");
    p.acc(0, 0, 16'h0150, 16'h0800, q);
    tick(3);
    chk({14'h0, irq_oe, irq_o}, 16'h0002, "merged pin");
    ev.sync_out = 2'b00;
    p.acc(0, 0, 16'h0150, 16'h0000, q);
    tick(2);
    chk({14'h0, latch_en}, 16'h0000, "latch use");
    $display("pin test done");
    dg_in = '{valid: 1'b1, irq_field: 16'h8000};
    p.acc(1, 0, 16'h0200, 16'h0002, q);
    pev('{latch_event: 2'b01, default: '0});
    chk(dg_out.irq_field, 16'h8002, "field");
    p.acc(1, 0, 16'h0200, 16'h0000, q);
    chk(dg_out.irq_field, 16'h8000, "field");
    p.acc(1, 0, 16'h0200, 16'h0032, q);
    pev('{latch_time_read: 2'b01, default: '0});
    tick(1);
    chk(dg_out.irq_field, 16'h8000, "field");
    p.acc(1, 0, 16'h0804, 16'h0030, q);
    pev('{chan_new_data: 8'h03, default: '0});
    tick(1);
    chk(dg_out.irq_field, 16'h8010, "field");
    p.acc(0, 1, 16'h0220, 16'h0000, q);
    chk(q & 16'hFF00, 16'h0100, "chan request");
    chk({15'h0, irq_o}, 16'h0000, "pending pin");
    pev('{chan_buf_read: 8'h01, default: '0});
    p.acc(0, 1, 16'h0220, 16'h0000, q);
    chk(q & 16'hFF00, 16'h0000, "chan request");
    $display("event test done");
    pev('{chan_new_data: 8'h01, default: '0});
    start = 1'b1;
    abort = 1'b1;
    tick(1);
    start = 1'b0;
    abort = 1'b0;
    chk(sirq & 16'hFF00, 16'h0100, "serial state");
    chk({15'h0, err}, 16'h0001, "abort error");
    tick(1);
    chk({15'h0, err}, 16'h0000, "abort error");
    $display("host interface test done");
    give_verdict();
  end
endmodule
`default_nettype wire
